// [hw/bus_cycle_engine.sv]
// single asynchronous flash bus cycle: write or read strobe timing
module bus_cycle_engine
  import flash_cmd_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic start, // one-cycle start pulse
  input wire logic isWrite, // 1 write cycle, 0 read cycle
  input wire logic [17:0] addr, // cycle address
  input wire logic [15:0] wdata, // write data
  input wire logic [15:0] pinDq, // synchronised data pins
  output logic done, // one-cycle done pulse
  output logic [15:0] rdata, // captured read data
  output logic [17:0] flashAddr, // address pins
  output logic [15:0] dqOut, // data out
  output logic dqOe, // data output enable
  output logic ceB, // chip enable, active low
  output logic weB, // write enable, active low
  output logic oeB // output enable, active low
);
  typedef enum logic [1:0] {Idle, Setup, Strobe, Hold} cyc_t;
  cyc_t st_q;
  logic [3:0] cnt_q;
  logic wr_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= Idle;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      flashAddr <= 18'h00000;
      dqOut <= 16'h0000;
      dqOe <= 1'b0;
      ceB <= 1'b1;
      weB <= 1'b1;
      oeB <= 1'b1;
      done <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (st_q)
        Idle: if (start) begin
          // address and data set up before the strobe falls
          wr_q <= isWrite;
          flashAddr <= addr;
          dqOut <= wdata;
          dqOe <= isWrite;
          ceB <= 1'b0;
          cnt_q <= SetupCyc;
          st_q <= Setup;
        end
        Setup: begin
          if (cnt_q <= 4'h1) begin
            // address latched on this falling edge
            weB <= ~wr_q;
            oeB <= wr_q;
            cnt_q <= wr_q ? WeLowCyc : RdAccCyc;
            st_q <= Strobe;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        Strobe: begin
          if (cnt_q <= 4'h1) begin
            // data latched on rising edge of write enable
            weB <= 1'b1;
            oeB <= 1'b1;
            if (!wr_q) rdata <= pinDq;
            st_q <= Hold;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        Hold: begin
          ceB <= 1'b1;
          dqOe <= 1'b0;
          done <= 1'b1;
          st_q <= Idle;
        end
      endcase
    end
  end
endmodule : bus_cycle_engine

// [hw/flash_cmd_host.sv]
// host controller issuing flash command sequences through the device pins
// Functional notes
// - all sequence cycles are writes except array read and final identifier read
// - reset command leaves identifier mode or recovers after timeout failure
// - identifier entry is two unlocks plus command, only when idle
// - program is two unlocks, setup, then address and data
// - bypass entry is two unlocks plus bypass entry command
// - bypass program is setup then address and data, repeated
// - bypass exit is 90h then 00h, returning to read mode
// - chip erase is six writes: unlocks, setup, unlocks, erase command
// - address latched on later falling edge, data on earlier rising edge
module flash_cmd_host
  import flash_cmd_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic reqValid, // user request valid
  output logic reqReady, // controller can take a request
  input wire flash_cmd_pkg::op_t reqOp, // requested operation
  input wire logic [17:0] reqAddr, // target address or id offset
  input wire logic [15:0] reqData, // program data
  input wire logic byteMode, // 1 byte width, 0 word width
  input wire logic hwResetReq, // pulse: assert device hardware reset
  output logic rspValid, // one-cycle answer pulse
  output logic [15:0] rspData, // read or status data
  output logic rspRefused, // one-cycle: request not legal now
  output logic busy, // sequence or device operation running
  output logic bypassMode, // unlock bypass active
  output logic idMode, // identifier mode active
  output logic suspended, // erase suspended
  output logic [17:0] flashAddr, // address pins
  output logic [15:0] dqOut, // data pins out
  output logic dqOe, // data pins drive enable
  input wire logic [15:0] dqIn, // data pins in
  output logic ceB, // chip enable, active low
  output logic weB, // write enable, active low
  output logic oeB, // output enable, active low
  output logic resetB, // device hardware reset, active low
  output logic byteB, // width select, low for byte
  input wire logic readyBusyIn // device ready_busy_out pin
);
  import flash_cmd_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [15:0] dqS1_q, dqS2_q;
  logic rbS1_q, rbS2_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dqS1_q <= 16'h0000;
      dqS2_q <= 16'h0000;
      rbS1_q <= 1'b1;
      rbS2_q <= 1'b1;
    end else begin
      dqS1_q <= dqIn;
      dqS2_q <= dqS1_q;
      rbS1_q <= readyBusyIn;
      rbS2_q <= rbS1_q;
    end
  end

  // ---------------------------------------------------------------
  // sequence step table
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {Idle, Issue, WaitCyc, WaitBusy, Respond} st_t;
  st_t st_q;
  op_t op_q;
  logic [2:0] step_q, nSteps;
  logic [17:0] addr_q, stepAddr;
  logic [15:0] data_q, stepData;
  logic stepWrite, cycStart, cycDone;
  logic [15:0] cycRdata;
  logic [17:0] uA, uB, idBase;
  logic refuse, wantsBusy;

  // unlock addresses scale with bus width
  assign uA = byteMode ? UnlockAddrAB : UnlockAddrAW;
  assign uB = byteMode ? UnlockAddrBB : UnlockAddrBW;
  assign idBase = byteMode ? {addr_q[16:0], 1'b0} : addr_q;

  always_comb begin
    nSteps = 3'd1;
    stepWrite = 1'b1;
    stepAddr = uA;
    stepData = {8'h00, CmdReset}; // upper byte zero in commands
    unique case (op_q)
      OpReadArray: begin
        stepWrite = 1'b0; // plain array read
        stepAddr = addr_q;
      end
      OpReset: stepAddr = 18'h00000; // address don't care
      OpIdRead: begin
        stepWrite = 1'b0; // repeated reads without re-entry
        stepAddr = idBase; // offsets 00h/01h/02h, 40h continuation
      end
      OpSuspend: begin
        stepAddr = 18'h00000;
        stepData = {8'h00, CmdSuspend};
      end
      OpResume: begin
        stepAddr = 18'h00000;
        stepData = {8'h00, CmdResume};
      end
      OpBypassProgram: begin
        nSteps = 3'd2; // setup then address/data
        stepAddr = (step_q == 3'd0) ? 18'h00000 : addr_q;
        stepData = (step_q == 3'd0) ? {8'h00, CmdProgram} : data_q;
      end
      OpBypassExit: begin
        nSteps = 3'd2;
        stepAddr = 18'h00000;
        stepData = {8'h00, (step_q == 3'd0) ? CmdIdent : CmdBypassExit2};
      end
      default: begin
        // unlock-prefixed sequences
        nSteps = (op_q == OpChipErase) ? 3'd6 : (op_q == OpProgram) ? 3'd4 : 3'd3;
        unique case (step_q)
          3'd0: begin
            stepAddr = uA;
            stepData = {8'h00, DataUnlock1};
          end
          3'd3: begin
            // fourth program cycle carries address and data; erase repeats the unlock
            stepAddr = (op_q == OpChipErase) ? uA : addr_q;
            stepData = (op_q == OpChipErase) ? {8'h00, DataUnlock1} : data_q;
          end
          3'd1, 3'd4: begin
            stepAddr = uB;
            stepData = {8'h00, DataUnlock2};
          end
          3'd2: begin
            stepAddr = uA;
            unique case (op_q)
              OpIdEnter: stepData = {8'h00, CmdIdent};
              OpProgram: stepData = {8'h00, CmdProgram};
              OpBypassEnter: stepData = {8'h00, CmdBypassEnter};
              default: stepData = {8'h00, CmdEraseSetup};
            endcase
          end
          3'd5: begin
            stepAddr = uA;
            stepData = {8'h00, CmdChipErase};
          end
          default: begin
            stepAddr = addr_q; // program address and data
            stepData = data_q;
          end
        endcase
      end
    endcase
  end

  // legality of the request against tracked device mode
  always_comb begin
    unique case (reqOp)
      OpIdEnter: refuse = bypassMode || idMode;
      OpIdRead: refuse = !idMode;
      OpSuspend: refuse = 1'b1; // only sector erase may be suspended
      OpResume: refuse = !suspended;
      OpBypassProgram, OpBypassExit: refuse = !bypassMode;
      OpChipErase, OpBypassEnter: refuse = bypassMode || idMode || suspended;
      OpProgram, OpReadArray: refuse = bypassMode || idMode;
      OpReset: refuse = bypassMode;
      default: refuse = 1'b1;
    endcase
  end

  assign wantsBusy = (op_q == OpProgram) || (op_q == OpBypassProgram) || (op_q == OpChipErase);
  assign reqReady = (st_q == Idle) && !hwResetReq;
  assign cycStart = (st_q == Issue);
  assign busy = (st_q != Idle);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  logic [3:0] busyWait_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= Idle;
      op_q <= OpReadArray;
      step_q <= 3'd0;
      addr_q <= 18'h00000;
      data_q <= 16'h0000;
      busyWait_q <= 4'h0;
      rspValid <= 1'b0;
      rspRefused <= 1'b0;
      rspData <= 16'h0000;
    end else begin
      rspValid <= 1'b0;
      rspRefused <= 1'b0;
      if (hwResetReq) begin
        st_q <= Idle; // hardware reset ends any operation
      end else begin
        unique case (st_q)
          Idle: if (reqValid) begin
            if (refuse) begin
              rspValid <= 1'b1;
              rspRefused <= 1'b1;
            end else begin
              op_q <= reqOp;
              addr_q <= reqAddr;
              data_q <= reqData;
              step_q <= 3'd0;
              st_q <= Issue;
            end
          end
          Issue: st_q <= WaitCyc;
          WaitCyc: if (cycDone) begin
            if (step_q + 3'd1 < nSteps) begin
              step_q <= step_q + 3'd1;
              st_q <= Issue;
            end else if (wantsBusy) begin
              busyWait_q <= 4'h4; // allow ready/busy to fall and sync
              st_q <= WaitBusy;
            end else begin
              rspData <= stepWrite ? 16'h0000 : cycRdata;
              st_q <= Respond;
            end
          end
          WaitBusy: begin
            // no command written until ready/busy returns high
            if (busyWait_q != 4'h0) busyWait_q <= busyWait_q - 4'h1;
            else if (rbS2_q) st_q <= Respond;
          end
          Respond: begin
            rspValid <= 1'b1;
            st_q <= Idle;
          end
          default: st_q <= Idle;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // tracked device mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bypassMode <= 1'b0;
      idMode <= 1'b0;
      suspended <= 1'b0;
    end else if (hwResetReq) begin
      bypassMode <= 1'b0;
      idMode <= 1'b0;
      suspended <= 1'b0;
    end else if (st_q == Respond) begin
      unique case (op_q)
        OpIdEnter: idMode <= 1'b1;
        OpReset: idMode <= 1'b0; // back to read or suspend-read
        OpBypassEnter: bypassMode <= 1'b1;
        OpBypassExit: bypassMode <= 1'b0;
        OpResume: suspended <= 1'b0;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // reset and width pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetB <= 1'b0;
      byteB <= 1'b1;
    end else begin
      resetB <= !hwResetReq;
      byteB <= !byteMode;
    end
  end

  bus_cycle_engine u_cycle (
    .clk(clk), .rst_b(rst_b), .start(cycStart), .isWrite(stepWrite), .addr(stepAddr), .wdata(stepData),
    .pinDq(dqS2_q), .done(cycDone), .rdata(cycRdata), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe),
    .ceB(ceB), .weB(weB), .oeB(oeB)
  );
endmodule : flash_cmd_host

// [hw/flash_cmd_pkg.sv]
// package: constants for the flash command sequencer host controller
package flash_cmd_pkg;
  localparam int AddrW = 18;
  localparam int DataW = 16;

  // unlock addresses for word width; byte width uses shifted forms
  localparam logic [17:0] UnlockAddrAW = 18'h00555;
  localparam logic [17:0] UnlockAddrBW = 18'h002aa;
  localparam logic [17:0] UnlockAddrAB = 18'h00aaa;
  localparam logic [17:0] UnlockAddrBB = 18'h00555;

  localparam logic [7:0] DataUnlock1 = 8'haa;
  localparam logic [7:0] DataUnlock2 = 8'h55;
  localparam logic [7:0] CmdIdent = 8'h90;
  localparam logic [7:0] CmdProgram = 8'ha0;
  localparam logic [7:0] CmdBypassEnter = 8'h20;
  localparam logic [7:0] CmdEraseSetup = 8'h80;
  localparam logic [7:0] CmdChipErase = 8'h10;
  localparam logic [7:0] CmdReset = 8'hf0;
  localparam logic [7:0] CmdSuspend = 8'hb0;
  localparam logic [7:0] CmdResume = 8'h30;
  localparam logic [7:0] CmdBypassExit2 = 8'h00;

  // identifier read offsets (word width)
  localparam logic [17:0] IdMakerOff = 18'h00000;
  localparam logic [17:0] IdDeviceOff = 18'h00001;
  localparam logic [17:0] IdProtectOff = 18'h00002;
  localparam logic [17:0] IdContOff = 18'h00040;

  // bus cycle timing at 20 MHz (50 ns)
  localparam int ClkNs = 50;
  localparam int WeLowNs = 100;
  localparam int RdAccNs = 120;
  localparam int SetupNs = 50;
  localparam logic [3:0] WeLowCyc = 4'((WeLowNs + ClkNs - 1) / ClkNs);
  localparam logic [3:0] RdAccCyc = 4'((RdAccNs + ClkNs - 1) / ClkNs);
  localparam logic [3:0] SetupCyc = 4'((SetupNs + ClkNs - 1) / ClkNs);

  typedef enum logic [3:0] {
    OpReadArray, OpReset, OpIdEnter, OpIdRead, OpProgram, OpBypassEnter,
    OpBypassProgram, OpBypassExit, OpChipErase, OpSuspend, OpResume
  } op_t;
endpackage : flash_cmd_pkg

// [tb/flash_cmd_host_sva.sv]
// checker: pin and handshake properties of the flash command host
module flash_cmd_host_chk
  import flash_cmd_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic reqValid, // request valid
  input wire logic reqReady, // request ready
  input wire flash_cmd_pkg::op_t reqOp, // operation
  input wire logic hwResetReq, // hardware reset request
  input wire logic rspValid, // answer pulse
  input wire logic rspRefused, // refusal pulse
  input wire logic bypassMode, // bypass flag
  input wire logic idMode, // identifier flag
  input wire logic [17:0] flashAddr, // address pins
  input wire logic [15:0] dqOut, // data out
  input wire logic dqOe, // data drive enable
  input wire logic ceB, // chip enable, active low
  input wire logic weB, // write enable, active low
  input wire logic oeB, // output enable, active low
  input wire logic resetB, // device reset, active low
  input wire logic readyBusyIn // device ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic weQ;
  logic [3:0] weCnt;
  op_t opQ;
  function automatic logic [3:0] wrCount(input op_t op);
    case (op)
      OpProgram: return 4'h4;
      OpChipErase: return 4'h6;
      OpIdEnter, OpBypassEnter: return 4'h3;
      OpBypassProgram, OpBypassExit: return 4'h2;
      OpReset: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction : wrCount
  // write strobes counted per accepted request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      weQ <= 1'b1;
      weCnt <= 4'h0;
      opQ <= OpReadArray;
    end else begin
      weQ <= weB;
      if (reqValid && reqReady) begin
        weCnt <= 4'h0;
        opQ <= reqOp;
      end else if (weQ && !weB) weCnt <= weCnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  strobe_overlap_a: assert property (!(!weB && !oeB))
    else $error("write and read strobes overlap");
  read_release_a: assert property (!oeB |-> !dqOe)
    else $error("data driven during read");
  we_inside_ce_a: assert property (!weB |-> !ceB && dqOe && $stable(flashAddr) && $stable(dqOut))
    else $error("write pulse not framed");
  we_width_a: assert property ($fell(weB) |=> !weB ##1 weB)
    else $error("write pulse width wrong");
  write_count_a: assert property (rspValid && !rspRefused |-> weCnt == wrCount(opQ))
    else $error("wrong number of write cycles");
  upper_byte_a: assert property (!weB && !(opQ inside {OpProgram, OpBypassProgram}) |-> dqOut[15:8] == 8'h00)
    else $error("upper byte set in command cycle");
  suspend_refuse_a: assert property (reqValid && reqReady && reqOp == OpSuspend |=> rspValid && rspRefused)
    else $error("suspend not refused");
  bypass_refuse_a: assert property (reqValid && reqReady && bypassMode &&
    reqOp inside {OpIdEnter, OpProgram, OpChipErase} |=> rspRefused)
    else $error("command accepted in bypass");
  idread_refuse_a: assert property (reqValid && reqReady && !idMode && reqOp == OpIdRead |=> rspRefused)
    else $error("identifier read outside identifier mode");
  done_ready_a: assert property (rspValid |-> $past(readyBusyIn, 2))
    else $error("answer before device ready");
  hw_reset_a: assert property (hwResetReq |=> !resetB)
    else $error("hardware reset not driven");
  cover property (rspValid && !rspRefused && opQ == OpProgram);
  cover property ($rose(idMode));
  cover property ($rose(bypassMode));
  cover property (rspValid && rspRefused);
endmodule : flash_cmd_host_chk

// [tb/flash_dev_model.sv]
// behavioural flash device model facing the host controller pins
module flash_dev_model
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] MakerCode = 8'h3c, // arbitrary value
  parameter logic [7:0] DevCode = 8'h5a, // arbitrary value
  parameter logic [7:0] ContCode = 8'h6e, // arbitrary value
  parameter logic [63:0] ProtMap = 64'h2, // sector 1 protected
  parameter int BusyCyc = 40 // internal operation length
)(
  input wire logic clk, // samples pin edges
  input wire logic resetB, // hardware reset, active low
  input wire logic byteB, // low selects byte width
  input wire logic ceB, // chip enable, active low
  input wire logic weB, // write enable, active low
  input wire logic oeB, // output enable, active low
  input wire logic [17:0] flashAddr, // address pins
  input wire logic [15:0] dqOut, // data from host
  output logic [15:0] dqIn, // data to host
  output logic readyBusyIn // low while busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:31];
  logic [17:0] aLat;
  logic [15:0] lastRd;
  logic weQ, idM, bypM, pgmPend, exitPend, tog;
  logic [2:0] step;
  logic [10:0] a, u1, u2;
  logic [7:0] d;
  logic [6:0] idOff;
  int busyCnt;
  function automatic int ix(input logic [17:0] x);
    return int'({x[12], x[3:0]});
  endfunction : ix
  initial for (int i = 0; i < 32; i++) mem[i] = (i < 16) ? 16'hffff : 16'h5a5a;
  assign u1 = byteB ? 11'h555 : 11'haaa;
  assign u2 = byteB ? 11'h2aa : 11'h555;
  assign a = aLat[10:0];
  assign d = dqOut[7:0];
  assign idOff = byteB ? flashAddr[6:0] : flashAddr[7:1];
  assign readyBusyIn = (busyCnt == 0);
  always_comb begin
    if (!resetB || ceB || oeB) dqIn = ~lastRd;
    else if (busyCnt != 0) dqIn = {9'h000, tog, 6'h00};
    else if (idM) begin
      case (idOff)
        7'h00: dqIn = {8'h00, MakerCode};
        7'h01: dqIn = {8'h00, DevCode};
        7'h02: dqIn = {15'h0000, ProtMap[flashAddr[17:12]]};
        7'h40: dqIn = {8'h00, ContCode};
        default: dqIn = 16'h0000;
      endcase
    end else dqIn = mem[ix(flashAddr)];
  end
  // suspend and resume are never decoded: no sector erase here
  always @(posedge clk or negedge resetB) begin
    if (!resetB) begin
      {idM, bypM, pgmPend, exitPend, tog} <= 5'h00;
      step <= 3'h0;
      busyCnt <= 0;
      weQ <= 1'b1;
    end else begin
      weQ <= weB;
      if (busyCnt > 0) busyCnt <= busyCnt - 1;
      if (busyCnt > 0) tog <= ~tog;
      if (!ceB && !oeB) lastRd <= dqIn;
      if (weQ && !weB && !ceB) aLat <= flashAddr;
      if (!weQ && weB && !ceB && busyCnt == 0) begin
        if (bypM) begin
          if (pgmPend) begin
            mem[ix(aLat)] <= mem[ix(aLat)] & dqOut;
            busyCnt <= BusyCyc;
            pgmPend <= 1'b0;
          end else if (exitPend) begin
            bypM <= (d != CmdBypassExit2);
            exitPend <= 1'b0;
          end else begin
            pgmPend <= (d == CmdProgram);
            exitPend <= (d == CmdIdent);
          end
        end else if (pgmPend) begin
          mem[ix(aLat)] <= mem[ix(aLat)] & dqOut;
          busyCnt <= BusyCyc;
          pgmPend <= 1'b0;
        end else if (d == CmdReset) begin
          step <= 3'h0;
          idM <= 1'b0;
        end else if (!idM) begin
          case (step)
            3'h0: step <= (a == u1 && d == DataUnlock1) ? 3'h1 : 3'h0;
            3'h1: step <= (a == u2 && d == DataUnlock2) ? 3'h2 : 3'h0;
            3'h2: begin
              step <= (a == u1 && d == CmdEraseSetup) ? 3'h3 : 3'h0;
              idM <= (a == u1 && d == CmdIdent);
              pgmPend <= (a == u1 && d == CmdProgram);
              bypM <= (a == u1 && d == CmdBypassEnter);
            end
            3'h3: step <= (a == u1 && d == DataUnlock1) ? 3'h4 : 3'h0;
            3'h4: step <= (a == u2 && d == DataUnlock2) ? 3'h5 : 3'h0;
            default: begin
              step <= 3'h0;
              if (a == u1 && d == CmdChipErase) begin
                busyCnt <= BusyCyc * 4;
                for (int i = 0; i < 32; i++) if (!ProtMap[i / 16]) mem[i] <= 16'hffff;
              end
            end
          endcase
        end
      end
    end
  end
endmodule : flash_dev_model

// [tb/testbench.sv]
// testbench: command sequences against a behavioural flash device
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin badCount++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] Maker = 8'h3c; // arbitrary value
  localparam logic [7:0] Dev = 8'h5a; // arbitrary value
  localparam logic [7:0] Cont = 8'h6e; // arbitrary value
  logic clk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, byteMode = 1'b0, hwResetReq = 1'b0;
  op_t reqOp = OpReadArray;
  logic [17:0] reqAddr = 18'h00000, flashAddr;
  logic [15:0] reqData = 16'h0000, rspData, dqOut, dqIn, rd;
  logic reqReady, rspValid, rspRefused, busy, bypassMode, idMode, suspended, dqOe, ceB, weB, oeB, resetB, byteB;
  logic readyBusyIn, rf;
  int badCount = 0, checked = 0, cycles = 0;
  op_t refOps [5] = '{OpIdRead, OpSuspend, OpResume, OpBypassProgram, OpBypassExit};
  flash_cmd_host i_dut (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
    .reqAddr(reqAddr), .reqData(reqData), .byteMode(byteMode), .hwResetReq(hwResetReq), .rspValid(rspValid),
    .rspData(rspData), .rspRefused(rspRefused), .busy(busy), .bypassMode(bypassMode), .idMode(idMode),
    .suspended(suspended), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .ceB(ceB),
    .weB(weB), .oeB(oeB), .resetB(resetB), .byteB(byteB), .readyBusyIn(readyBusyIn));
  flash_dev_model #(.MakerCode(Maker), .DevCode(Dev), .ContCode(Cont)) i_dev (.clk(clk), .resetB(resetB),
    .byteB(byteB), .ceB(ceB), .weB(weB), .oeB(oeB), .flashAddr(flashAddr), .dqOut(dqOut), .dqIn(dqIn),
    .readyBusyIn(readyBusyIn));
  always #25 clk = ~clk;
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // one request, held until taken; answer captured at its pulse
  task automatic req(input op_t op, input logic [17:0] a, input logic [15:0] d);
    logic ok;
    ok = 1'b0;
    reqOp <= op;
    reqAddr <= a;
    reqData <= d;
    reqValid <= 1'b1;
    while (!ok) begin
      @(negedge clk);
      ok = reqReady;
      @(posedge clk);
    end
    reqValid <= 1'b0;
    do @(negedge clk); while (rspValid !== 1'b1);
    rd = rspData;
    rf = rspRefused;
    @(posedge clk);
  endtask : req
  // hang guard: the whole sequence needs under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    req(OpReadArray, 18'h00003, 16'h0000); `CHK("array", 16'hffff, rd)
    `CHK("idle after read", 1'b0, busy)
    req(OpProgram, 18'h00003, 16'h1234); `CHK("pgm taken", 1'b0, rf)
    req(OpReadArray, 18'h00003, 16'h0000); `CHK("pgm read", 16'h1234, rd)
    req(OpProgram, 18'h00003, 16'hff30);
    req(OpReadArray, 18'h00003, 16'h0000); `CHK("zero kept", 16'h1230, rd)
    req(OpIdEnter, 18'h00000, 16'h0000); `CHK("id on", 1'b1, idMode)
    req(OpIdRead, 18'h3f001, 16'h0000); `CHK("device id", {8'h00, Dev}, rd)
    for (int i = 0; i < 4; i++) begin
      req(OpIdRead, 18'h00040, 16'h0000); `CHK("cont", {8'h00, Cont}, rd)
    end
    req(OpIdRead, 18'h00000, 16'h0000); `CHK("maker", {8'h00, Maker}, rd)
    req(OpIdRead, 18'h01002, 16'h0000); `CHK("prot", 16'h0001, rd)
    req(OpIdRead, 18'h02002, 16'h0000); `CHK("unprot", 16'h0000, rd)
    req(OpProgram, 18'h00003, 16'h0000); `CHK("pgm in id", 1'b1, rf)
    req(OpReset, 18'h00000, 16'h0000); `CHK("id off", 1'b0, idMode)
    req(OpReadArray, 18'h00003, 16'h0000); `CHK("read back", 16'h1230, rd)
    byteMode <= 1'b1;
    req(OpIdEnter, 18'h00000, 16'h0000);
    req(OpIdRead, 18'h00001, 16'h0000); `CHK("byte dev id", {8'h00, Dev}, rd)
    `CHK("byte pin", 1'b0, byteB)
    hwResetReq <= 1'b1;
    @(posedge clk);
    hwResetReq <= 1'b0;
    byteMode <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("hw reset", 1'b0, idMode)
    @(posedge clk);
    req(OpBypassEnter, 18'h00000, 16'h0000); `CHK("bypass on", 1'b1, bypassMode)
    req(OpBypassProgram, 18'h00005, 16'h00f0); `CHK("bpgm 1", 1'b0, rf)
    req(OpBypassProgram, 18'h00006, 16'h0a0a); `CHK("bpgm 2", 1'b0, rf)
    req(OpIdEnter, 18'h00000, 16'h0000); `CHK("id in bypass", 1'b1, rf)
    req(OpBypassExit, 18'h00000, 16'h0000); `CHK("bypass off", 1'b0, bypassMode)
    req(OpReadArray, 18'h00005, 16'h0000); `CHK("bpgm read 1", 16'h00f0, rd)
    req(OpReadArray, 18'h00006, 16'h0000); `CHK("bpgm read 2", 16'h0a0a, rd)
    foreach (refOps[i]) begin
      req(refOps[i], 18'h00000, 16'h0000); `CHK("refused", 1'b1, rf)
      `CHK("not suspended", 1'b0, suspended)
    end
    req(OpChipErase, 18'h00000, 16'h0000); `CHK("erase taken", 1'b0, rf)
    req(OpReadArray, 18'h00003, 16'h0000); `CHK("erased", 16'hffff, rd)
    req(OpReadArray, 18'h01004, 16'h0000); `CHK("protected kept", 16'h5a5a, rd)
    report_and_stop();
  end
endmodule : testbench
bind flash_cmd_host flash_cmd_host_chk i_chk (.clk, .rst_b, .reqValid, .reqReady, .reqOp, .hwResetReq, .rspValid,
  .rspRefused, .bypassMode, .idMode, .flashAddr, .dqOut, .dqOe, .ceB, .weB, .oeB, .resetB, .readyBusyIn);
